// File: inc/cdd_defs.svh
`ifndef CDD_DEFS_SVH
`define CDD_DEFS_SVH
`define CDD_ADDR_CMD       2'h0
`define CDD_ADDR_DATA      2'h1
`define CDD_ADDR_CFG0      2'h2
`define CDD_ADDR_CFG1      2'h3
`define CDD_CMD_FUNC_B     8'h72
`define CDD_CMD_REGUL      8'h71
`define CDD_CMD_CONTRAST   8'h81
`define CDD_CMD_CLKDIV     8'hD5
`define CDD_CMD_PHASE      8'hD9
`define CDD_CMD_SEGCFG     8'hDA
`define CDD_CMD_FUNC_C     8'hDC
`define CDD_CMD_FADE       8'h23
`define CDD_REGUL_OFF      8'h00
`define CDD_REGUL_ON       8'h5C
`define CDD_RST_CONTRAST   8'h7F
`define CDD_RST_CLKDIV     8'h70
`define CDD_RST_PHASE      8'h78
`define CDD_RST_GPIO       2'h2
`define CDD_SCROLL_MAX     6'h30
`define CDD_PART_ID        7'h2A
`define CDD_BUSY_CYCLES    4'h4
`endif

// File: inc/cdd_pkg.sv
package cdd_pkg;
   typedef enum logic [2:0] {
      CDD_IDLE  = 3'b001,
      CDD_PARAM = 3'b010,
      CDD_BUSY  = 3'b100
   } cdd_state_type;
   typedef struct packed {
      logic       ext_select_low;
      logic       ext_page_bit;
      logic       oled_cmd_page;
      logic       four_row_mode;
      logic       two_rows;
      logic       double_height;
      logic       glyph_blink_on;
      logic       invert_all;
      logic       entry_up;
      logic       column_dir;
   } cdd_mode_type;
   typedef struct packed {
      logic [7:0] contrast;
      logic [7:0] clk_div;
      logic [7:0] phase_len;
      logic [5:0] scroll_amount;
      logic [1:0] glyph_split;
      logic [1:0] font_table_sel;
      logic [1:0] gpio_mode;
      logic [1:0] fade_mode;
      logic [3:0] fade_step;
      logic       seg_alt;
      logic       seg_swap;
      logic       regul_on;
   } cdd_cfg_type;
endpackage

// File: src/cdd_ram.sv
`timescale 1ns/1ps
module cdd_ram (
   input  wire logic       core_clk,
   input  wire logic       clk_en,
   input  wire logic       we,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:255];
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end
endmodule

// File: src/cdd_decoder.sv
`timescale 1ns/1ps
`include "cdd_defs.svh"
// Notes on behaviour
// - function set, ext clear: bit3 picks two/four rows or one/three rows.
// - same form: bit2 double height, bits1..0 load page-select bits.
// - ext set: bit2 is glyph blink enable, bit1 still writes ext bit.
// - ext set: bit0 inverts all characters; normal at reset.
// - 01xxxxxx with both ext bits clear loads glyph RAM address.
// - bit7 set, ext clear loads seven-bit character RAM address.
// - bit7 set, ext set stores six-bit scroll amount, above 30h invalid.
// - status read gives busy and address; second consecutive read gives part id.
// - data write stores byte into the RAM the address counter points at.
// - data read returns byte at the current RAM address.
// - 71h then 00h disables regulator, 5Ch enables; enabled at reset.
// - 72h parameter bits1..0 set glyph split.
// - 72h parameter bits3..2 select font table; 11b invalid.
// - 78h/79h with ext set write bit0 into oled page bit.
// - when locked, reject commands unless oled page bit set.
// - 81h parameter is contrast, reset 7Fh.
// - D5h parameter: low nibble clock divide, high nibble oscillator.
// - D9h low nibble discharge phase length, reset 1000b.
// - D9h high nibble charge phase length, zero invalid, reset 0111b.
// - DAh bit4 alternating segment pins, bit5 left/right swap.
// - DCh bits1..0 set general-purpose pin mode.
// - 23h bits5..4 select fade mode.
// - 23h bits3..0 set fade step interval, eight frames per count.
// - segment order follows odd/even, direction and swap bits.
// - codes decode by the current page-select bits.
// - address counter steps by one after each data access, per entry direction.
module cdd_decoder
   import cdd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        if_locked,
   input  wire logic        gpio_in,
   output logic             gpio_out,
   output logic             gpio_oe,
   output logic [2:0]       seg_order,
   output cdd_mode_type     mode,
   output cdd_cfg_type      cfg
);
   cdd_state_type st_q, st_d;
   cdd_mode_type  mode_q, mode_d;
   cdd_cfg_type   cfg_q, cfg_d;
   logic [7:0]  pcmd_q, pcmd_d;
   logic [6:0]  ac_q, ac_d;
   logic        glyph_sel_q, glyph_sel_d;
   logic [3:0]  busy_q, busy_d;
   logic        stat_rd_q, stat_rd_d;
   logic [1:0]  rd_cnt_q, rd_cnt_d;
   logic [1:0]  rd_need;
   logic        rd_take;
   logic [31:0] rdata_q, rdata_d;
   logic        gpio_s1_q, gpio_s2_q;
   logic        lock_s1_q, lock_s2_q;
   logic        ram_we;
   logic [7:0]  ram_addr;
   logic [7:0]  ram_rdata;
   logic [7:0]  wb;
   logic        is_cmd_wr, is_dat_wr, is_cmd_rd, is_dat_rd, is_cfg_rd, accept;

   assign wb        = avs_writedata[7:0];
   assign is_cmd_wr = avs_write && (avs_address == `CDD_ADDR_CMD);
   assign is_dat_wr = avs_write && (avs_address == `CDD_ADDR_DATA);
   assign is_cmd_rd = avs_read && (avs_address == `CDD_ADDR_CMD);
   assign is_dat_rd = avs_read && (avs_address == `CDD_ADDR_DATA);
   assign is_cfg_rd = avs_read && avs_address[1];
   // reads hold until read data stand in the output register; RAM reads need one more cycle
   assign rd_need         = is_dat_rd ? 2'h2 : 2'h1;
   assign avs_waitrequest = avs_read && (rd_cnt_q != rd_need);
   assign rd_take         = avs_read && !avs_waitrequest;
   // locked interface ignores command writes until the oled page bit is set
   assign accept = !lock_s2_q || mode_q.oled_cmd_page;
   assign ram_addr = glyph_sel_q ? {2'h0, ac_q[5:0]} : {1'h1, ac_q};
   assign ram_we   = clk_en && is_dat_wr;

   cdd_ram u_ram (
      .core_clk (core_clk),
      .clk_en   (clk_en),
      .we       (ram_we),
      .addr     (ram_addr),
      .wdata    (wb),
      .rdata    (ram_rdata)
   );

   always_comb begin
      st_d        = st_q;
      mode_d      = mode_q;
      cfg_d       = cfg_q;
      pcmd_d      = pcmd_q;
      ac_d        = ac_q;
      glyph_sel_d = glyph_sel_q;
      busy_d      = (busy_q != 4'h0) ? busy_q - 4'h1 : 4'h0;
      stat_rd_d   = stat_rd_q;
      rd_cnt_d    = 2'h0;
      rdata_d     = rdata_q;
      if (avs_read && avs_waitrequest) begin
         rd_cnt_d = rd_cnt_q + 2'h1;
      end
      if (is_cmd_wr || is_dat_wr || ((is_dat_rd || is_cfg_rd) && rd_take)) begin
         stat_rd_d = 1'b0;
      end
      if (is_cmd_rd && rd_cnt_q == 2'h0) begin
         rdata_d   = stat_rd_q ? {24'h0, busy_q != 4'h0, `CDD_PART_ID} : {24'h0, busy_q != 4'h0, ac_q};
      end
      if (is_cmd_rd && rd_take) begin
         stat_rd_d = !stat_rd_q;
      end
      if (is_cfg_rd && rd_cnt_q == 2'h0) begin
         rdata_d = avs_address[0] ? {10'h0, cfg_q.scroll_amount, cfg_q.glyph_split, cfg_q.font_table_sel,
                                     cfg_q.gpio_mode, cfg_q.fade_mode, cfg_q.fade_step, cfg_q.seg_alt,
                                     cfg_q.seg_swap, cfg_q.regul_on,
                                     gpio_s2_q && (cfg_q.gpio_mode == 2'h1)}
                                  : {cfg_q.clk_div, cfg_q.phase_len, 6'h0, mode_q};
      end
      if (is_dat_rd && rd_cnt_q == 2'h1) begin
         rdata_d = {24'h0, ram_rdata};
      end
      if (is_dat_rd && rd_take) begin
         ac_d = mode_q.entry_up ? ac_q + 7'h1 : ac_q - 7'h1;
      end
      if (is_dat_wr) begin
         ac_d = mode_q.entry_up ? ac_q + 7'h1 : ac_q - 7'h1;
      end
      if (is_cmd_wr && accept) begin
         busy_d = `CDD_BUSY_CYCLES;
         unique case (st_q)
            CDD_PARAM: begin
               st_d = CDD_IDLE;
               unique case (pcmd_q)
                  `CDD_CMD_REGUL: begin
                     if (wb == `CDD_REGUL_OFF) cfg_d.regul_on = 1'b0;
                     else if (wb == `CDD_REGUL_ON) cfg_d.regul_on = 1'b1;
                  end
                  `CDD_CMD_FUNC_B: begin
                     cfg_d.glyph_split = wb[1:0];
                     if (wb[3:2] != 2'h3) cfg_d.font_table_sel = wb[3:2];
                  end
                  `CDD_CMD_CONTRAST: cfg_d.contrast = wb;
                  `CDD_CMD_CLKDIV:   cfg_d.clk_div = wb;
                  `CDD_CMD_PHASE: begin
                     cfg_d.phase_len[3:0] = wb[3:0];
                     if (wb[7:4] != 4'h0) cfg_d.phase_len[7:4] = wb[7:4];
                  end
                  `CDD_CMD_SEGCFG: begin
                     cfg_d.seg_alt  = wb[4];
                     cfg_d.seg_swap = wb[5];
                  end
                  `CDD_CMD_FUNC_C: cfg_d.gpio_mode = wb[1:0];
                  `CDD_CMD_FADE: begin
                     if (wb[5:4] != 2'h1) cfg_d.fade_mode = wb[5:4];
                     cfg_d.fade_step = wb[3:0];
                  end
                  default: ;
               endcase
            end
            default: begin
               if (mode_q.oled_cmd_page && mode_q.ext_page_bit) begin
                  if (wb == `CDD_CMD_CONTRAST || wb == `CDD_CMD_CLKDIV || wb == `CDD_CMD_PHASE ||
                      wb == `CDD_CMD_SEGCFG || wb == `CDD_CMD_FUNC_C || wb == `CDD_CMD_FADE ||
                      wb == 8'hDB) begin
                     pcmd_d = wb;
                     st_d   = CDD_PARAM;
                  end
                  if (wb[7:1] == 7'h3C) mode_d.oled_cmd_page = wb[0];
               end else if (wb[7:5] == 3'h1) begin
                  mode_d.ext_page_bit = wb[1];
                  if (!mode_q.ext_page_bit) begin
                     mode_d.two_rows       = wb[3];
                     mode_d.double_height  = wb[2];
                     mode_d.ext_select_low = wb[0];
                  end else begin
                     mode_d.two_rows       = wb[3];
                     mode_d.glyph_blink_on = wb[2];
                     mode_d.invert_all     = wb[0];
                  end
               end else if (wb[7]) begin
                  if (!mode_q.ext_page_bit) begin
                     ac_d        = wb[6:0];
                     glyph_sel_d = 1'b0;
                  end else if (wb[5:0] <= `CDD_SCROLL_MAX) begin
                     cfg_d.scroll_amount = wb[5:0];
                  end
               end else if (wb[7:6] == 2'h1) begin
                  if (!mode_q.ext_page_bit && !mode_q.ext_select_low) begin
                     ac_d        = {1'h0, wb[5:0]};
                     glyph_sel_d = 1'b1;
                  end else if (mode_q.ext_page_bit) begin
                     if (wb == `CDD_CMD_REGUL || wb == `CDD_CMD_FUNC_B) begin
                        pcmd_d = wb;
                        st_d   = CDD_PARAM;
                     end
                     if (wb[7:1] == 7'h3C) mode_d.oled_cmd_page = wb[0];
                  end
               end else if (wb[7:2] == 6'h01) begin
                  if (!mode_q.ext_page_bit) mode_d.entry_up = wb[1];
                  else mode_d.column_dir = wb[0];
               end else if (wb[7:3] == 5'h01 && mode_q.ext_page_bit) begin
                  mode_d.four_row_mode = wb[0];
               end else if (wb == 8'h01 || (wb[7:1] == 7'h01 && !mode_q.ext_page_bit)) begin
                  ac_d        = 7'h00;
                  glyph_sel_d = 1'b0;
                  if (wb == 8'h01) mode_d.entry_up = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q        <= CDD_IDLE;
         mode_q      <= '{ext_select_low: 1'b0, ext_page_bit: 1'b0, oled_cmd_page: 1'b0, four_row_mode: 1'b1,
                          two_rows: 1'b1, double_height: 1'b0, glyph_blink_on: 1'b0, invert_all: 1'b0,
                          entry_up: 1'b1, column_dir: 1'b1};
         cfg_q       <= '{contrast: `CDD_RST_CONTRAST, clk_div: `CDD_RST_CLKDIV, phase_len: `CDD_RST_PHASE,
                          scroll_amount: 6'h00, glyph_split: 2'h0, font_table_sel: 2'h0,
                          gpio_mode: `CDD_RST_GPIO, fade_mode: 2'h0, fade_step: 4'h0, seg_alt: 1'b1,
                          seg_swap: 1'b0, regul_on: 1'b1};
         pcmd_q      <= 8'h00;
         ac_q        <= 7'h00;
         glyph_sel_q <= 1'b0;
         busy_q      <= 4'h0;
         stat_rd_q   <= 1'b0;
         rd_cnt_q    <= 2'h0;
         rdata_q     <= 32'h0;
         gpio_s1_q   <= 1'b0;
         gpio_s2_q   <= 1'b0;
         lock_s1_q   <= 1'b0;
         lock_s2_q   <= 1'b0;
      end else if (clk_en) begin
         st_q        <= st_d;
         mode_q      <= mode_d;
         cfg_q       <= cfg_d;
         pcmd_q      <= pcmd_d;
         ac_q        <= ac_d;
         glyph_sel_q <= glyph_sel_d;
         busy_q      <= busy_d;
         stat_rd_q   <= stat_rd_d;
         rd_cnt_q    <= rd_cnt_d;
         rdata_q     <= rdata_d;
         gpio_s1_q   <= gpio_in;
         gpio_s2_q   <= gpio_s1_q;
         lock_s1_q   <= if_locked;
         lock_s2_q   <= lock_s1_q;
      end
   end

   always_comb begin
      avs_readdata = rdata_q;
      mode         = mode_q;
      cfg          = cfg_q;
      gpio_oe      = cfg_q.gpio_mode[1];
      gpio_out     = cfg_q.gpio_mode[0];
      seg_order    = {cfg_q.seg_alt, mode_q.column_dir, cfg_q.seg_swap};
   end

   a_ac_step: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_dat_wr && !is_cmd_wr && mode.entry_up |=> ac_q == $past(ac_q) + 7'h1)
      else $error("address counter did not step");
   a_busy_set: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_cmd_wr && accept |=> busy_q == `CDD_BUSY_CYCLES)
      else $error("busy not raised");
   a_lock_block: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_cmd_wr && lock_s2_q && !mode_q.oled_cmd_page |=> $stable(cfg_q))
      else $error("locked command changed config");
   a_scroll_range: assert property (@(posedge core_clk) disable iff (rst)
      cfg_q.scroll_amount <= `CDD_SCROLL_MAX)
      else $error("scroll amount out of range");
   a_charge_nonzero: assert property (@(posedge core_clk) disable iff (rst)
      cfg_q.phase_len[7:4] != 4'h0)
      else $error("charge phase zero");
   a_font_valid: assert property (@(posedge core_clk) disable iff (rst)
      cfg_q.font_table_sel != 2'h3)
      else $error("invalid font table");
   a_param_once: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st_q == CDD_PARAM && is_cmd_wr && accept |=> st_q == CDD_IDLE)
      else $error("parameter phase not closed");
   a_gpio_drive: assert property (@(posedge core_clk) disable iff (rst)
      gpio_oe == (cfg_q.gpio_mode[1]) && (!gpio_oe || gpio_out == cfg_q.gpio_mode[0]))
      else $error("gpio drive mismatch");
   a_id_read: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_cmd_rd && stat_rd_q |=> avs_readdata[6:0] == `CDD_PART_ID)
      else $error("part id not returned");
   a_rd_wait: assert property (@(posedge core_clk) disable iff (rst)
      is_dat_rd && rd_cnt_q == 2'h0 |-> avs_waitrequest)
      else $error("data read not held");
   a_regul_off: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st_q == CDD_PARAM && pcmd_q == `CDD_CMD_REGUL && is_cmd_wr && accept && wb == `CDD_REGUL_OFF
      |=> !cfg_q.regul_on)
      else $error("regulator not disabled");
   a_freeze: assert property (@(posedge core_clk) disable iff (rst)
      !clk_en |=> $stable(cfg_q) && $stable(mode_q))
      else $error("state moved while frozen");
endmodule

// File: sim/cdd_host.sv
`timescale 1ns/1ps
module cdd_host (
   input  wire logic        core_clk,
   output logic      [1:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address = 2'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= {24'h0, d};
      avs_write     <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write     <= 1'b0;
      avs_writedata <= ~{24'h0, d};
      @(posedge core_clk);
   endtask

   // read data taken at the edge that sees waitrequest low
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata[7:0];
      avs_read <= 1'b0;
   endtask

   // parameter bytes go through here too, right after their command
   task automatic cmd(input logic [7:0] c);
      logic [7:0] s;
      s = 8'hFF;
      while (s[7] !== 1'b0) rd(2'h0, s);
      wr(2'h0, c);
   endtask
endmodule

// File: sim/char_display_command_decoder_tb.sv
`timescale 1ns/1ps
`include "cdd_defs.svh"
module char_display_command_decoder_tb;
   import cdd_pkg::*;
   typedef struct packed {
      logic [1:0] pg;
      logic [7:0] c;
      logic [8:0] p;
      logic [2:0] s;
      logic [7:0] e;
   } cdd_row_type;

   logic         core_clk;
   logic         rst;
   logic         clk_en;
   logic         if_locked;
   logic         gpio_in;
   logic  [1:0]  avs_address;
   logic         avs_read;
   logic         avs_write;
   logic  [31:0] avs_writedata;
   logic  [31:0] avs_readdata;
   logic         avs_waitrequest;
   logic         gpio_out;
   logic         gpio_oe;
   logic  [2:0]  seg_order;
   cdd_mode_type mode;
   cdd_cfg_type  cfg;
   logic  [7:0]  a;
   logic  [7:0]  b;
   int           err_total = 0;
   int           n_checks = 0;

   // page 1 extended, 2 oled; p[8] marks a parameter byte
   cdd_row_type rows [0:21] = '{
      '{2'h1, 8'h71, 9'h100, 3'h7, 8'h00},
      '{2'h1, 8'h71, 9'h133, 3'h7, 8'h00},
      '{2'h1, 8'h71, 9'h15C, 3'h7, 8'h10},
      '{2'h1, 8'h72, 9'h10B, 3'h7, 8'h1B},
      '{2'h1, 8'h72, 9'h104, 3'h7, 8'h14},
      '{2'h1, 8'hB0, 9'h000, 3'h6, 8'h30},
      '{2'h1, 8'hB1, 9'h000, 3'h6, 8'h30},
      '{2'h2, 8'h81, 9'h1C8, 3'h0, 8'hC8},
      '{2'h2, 8'hD5, 9'h13A, 3'h1, 8'h3A},
      '{2'h2, 8'hD9, 9'h1F2, 3'h2, 8'hF2},
      '{2'h2, 8'hD9, 9'h10F, 3'h2, 8'hFF},
      '{2'h2, 8'hDA, 9'h120, 3'h3, 8'h03},
      '{2'h2, 8'hDA, 9'h130, 3'h3, 8'h07},
      '{2'h2, 8'hDA, 9'h110, 3'h3, 8'h06},
      '{2'h1, 8'h06, 9'h000, 3'h3, 8'h04},
      '{2'h1, 8'h07, 9'h000, 3'h3, 8'h06},
      '{2'h2, 8'h23, 9'h120, 3'h5, 8'h20},
      '{2'h2, 8'h23, 9'h13F, 3'h5, 8'h3F},
      '{2'h2, 8'h23, 9'h100, 3'h5, 8'h00},
      '{2'h2, 8'hDC, 9'h100, 3'h4, 8'h00},
      '{2'h2, 8'hDC, 9'h101, 3'h4, 8'h01},
      '{2'h2, 8'hDC, 9'h103, 3'h4, 8'h07}
   };

   cdd_decoder DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .if_locked(if_locked),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .seg_order(seg_order),
      .mode(mode), .cfg(cfg));

   cdd_host h (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] fld(input logic [2:0] s);
      case (s)
         3'h0: fld = cfg.contrast;
         3'h1: fld = cfg.clk_div;
         3'h2: fld = cfg.phase_len;
         3'h3: fld = {5'h0, seg_order};
         3'h4: fld = {5'h0, gpio_oe, cfg.gpio_mode};
         3'h5: fld = {2'h0, cfg.fade_mode, cfg.fade_step};
         3'h6: fld = {2'h0, cfg.scroll_amount};
         default: fld = {3'h0, cfg.regul_on, cfg.font_table_sel, cfg.glyph_split};
      endcase
   endfunction

   // other access first, so the pair starts afresh
   task automatic st(input logic [7:0] ea);
      repeat (8) @(posedge core_clk);
      h.rd(2'h2, a);
      h.rd(2'h0, a);
      h.rd(2'h0, b);
      chk(a, ea);
      chk(b, {1'b0, `CDD_PART_ID});
   endtask

   task automatic lock(input logic v);
      if_locked <= v;
      repeat (4) @(posedge core_clk);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      test_done();
   end

   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      if_locked = 1'b0;
      gpio_in = 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk(fld(3'h0), 8'h7F);
      chk(fld(3'h1), 8'h70);
      chk(fld(3'h2), 8'h78);
      chk(fld(3'h3), 8'h06);
      chk(fld(3'h6), 8'h00);
      chk({2'h0, mode.two_rows, mode.double_height, mode.glyph_blink_on, mode.invert_all,
           mode.oled_cmd_page, cfg.regul_on}, 8'h21);
      h.cmd(8'h24);
      chk({4'h0, mode.two_rows, mode.double_height, mode.ext_page_bit, mode.ext_select_low}, 8'h04);
      h.cmd(8'h29);
      chk({4'h0, mode.two_rows, mode.double_height, mode.ext_page_bit, mode.ext_select_low}, 8'h09);
      h.cmd(8'h55);
      st(8'h00);
      h.cmd(8'h28);
      h.cmd(8'h55);
      st(8'h15);
      h.wr(2'h1, 8'hA5);
      h.wr(2'h1, 8'h3C);
      st(8'h17);
      h.cmd(8'h55);
      h.rd(2'h1, a);
      chk(a, 8'hA5);
      h.rd(2'h1, a);
      chk(a, 8'h3C);
      h.cmd(8'hFF);
      st(8'h7F);
      chk(fld(3'h6), 8'h00);
      h.cmd(8'h2A);
      h.cmd(8'h2F);
      chk({5'h0, mode.glyph_blink_on, mode.invert_all, mode.ext_page_bit}, 8'h07);
      lock(1'b1);
      h.cmd(8'h2E);
      h.cmd(8'h79);
      chk({5'h0, mode.invert_all, mode.oled_cmd_page, mode.ext_page_bit}, 8'h05);
      lock(1'b0);
      h.cmd(8'h79);
      lock(1'b1);
      h.cmd(8'h81);
      h.cmd(8'h55);
      chk(fld(3'h0), 8'h55);
      lock(1'b0);
      foreach (rows[i]) begin
         h.cmd(rows[i].pg == 2'h2 ? 8'h79 : 8'h78);
         h.cmd(rows[i].c);
         if (rows[i].p[8]) h.cmd(rows[i].p[7:0]);
         if (rows[i].c == 8'h72) h.cmd(8'h01);
         @(posedge core_clk);
         chk(fld(rows[i].s), rows[i].e);
      end
      chk({7'h0, gpio_out}, 8'h01);
      clk_en <= 1'b0;
      h.wr(2'h0, 8'h81);
      h.wr(2'h0, 8'h11);
      clk_en <= 1'b1;
      @(posedge core_clk);
      chk(fld(3'h0), 8'hC8);
      h.cmd(8'h81);
      h.cmd(8'h22);
      chk(fld(3'h0), 8'h22);
      h.cmd(8'hDC);
      h.cmd(8'h01);
      gpio_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      h.rd(2'h3, a);
      chk({7'h0, a[0]}, 8'h01);
      h.cmd(8'hDC);
      h.cmd(8'h00);
      repeat (4) @(posedge core_clk);
      h.rd(2'h3, a);
      chk({7'h0, a[0]}, 8'h00);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk(fld(3'h0), 8'h7F);
      chk({6'h0, gpio_oe, gpio_out}, 8'h02);
      chk({7'h0, mode.oled_cmd_page}, 8'h00);
      st(8'h00);
      test_done();
   end
endmodule
